// >>> hdl/result_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module result_fifo import sar_pkg::*; #(
    parameter int WIDTH = WIDTH_WIDE,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic clk, // system clock
    input wire logic sys_rst, // synchronous reset, high
    input wire logic [WIDTH-1:0] in_data, // word to store
    input wire logic in_valid, // word offered
    output logic in_ready, // room available
    output logic [WIDTH-1:0] out_data, // oldest word
    output logic out_valid, // word available
    input wire logic out_ready // consumer takes word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW-1:0] rd_nxt;
    logic [AW:0] cnt_r;
    logic [AW:0] cnt_nxt;
    logic [WIDTH-1:0] out_data_r;
    logic out_valid_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid_r && out_ready;
    // the incoming word goes straight to the head when it is the only one left
    wire bypass = push && (wr_r == rd_nxt);
    // honest flags from the fill count
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign rd_nxt = !pop ? rd_r : (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
    assign cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    // head and valid are registered so the consumer sees flop outputs
    assign out_data = out_data_r;
    assign out_valid = out_valid_r;
    // storage array and head register have no reset, only data moves here
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
        out_data_r <= bypass ? in_data : mem[rd_nxt];
    end
    // pointers and fill level
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
            out_valid_r <= 1'b0;
        end else begin
            if (push) begin
                wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
            end
            rd_r <= rd_nxt;
            cnt_r <= cnt_nxt;
            out_valid_r <= (cnt_nxt != '0);
        end
    end
endmodule // result_fifo
`default_nettype wire

// >>> hdl/sar_pkg.sv
`default_nettype none
package sar_pkg;
    // register widths offered by the family
    localparam int WIDTH_NARROW = 8;
    localparam int WIDTH_WIDE = 12;
    localparam int FIFO_DEPTH = 32;
    // level that marks the bit under trial
    localparam logic TRIAL_LEVEL = 1'b0;
    // level of every bit that has not been tried yet
    localparam logic UNTRIED_LEVEL = 1'b1;
    // result word handed to the fifo
    typedef struct packed {
        logic [WIDTH_WIDE-1:0] code;
    } result_t;
endpackage
`default_nettype wire

// >>> hdl/sar_register.sv
`timescale 1ns/1ps
`default_nettype none
// Operation
// - width parameter selects the eight-bit or twelve-bit register variant
// - control state settles between edges, as master latches do with clock low
// - register bits change only on the rising clock edge
// - serial data input is loaded into the bit under trial each edge
// - serial output presents the bit just loaded
// - same edge drives next lower bit low as the new trial bit
// - start-stop or continuous conversion, both begun by start input
// - start low at edge resets: msb low, others high, done high
// - after lsb loads, done goes low and bits freeze until restart
// - enable high forces msb high and refuses data; single device ties low
// - inverted msb is provided as an extra output
module sar_register import sar_pkg::*; #(
    parameter int WIDTH = WIDTH_NARROW, // 8 or 12
    parameter int DEPTH = FIFO_DEPTH // result fifo depth
) (
    input wire logic clk, // register clock, rising edge active
    input wire logic sys_rst, // synchronous reset, high
    input wire logic start_n, // start, active low
    input wire logic enable_n, // cascade enable, active low
    input wire logic serial_in, // comparator decision
    output logic [WIDTH-1:0] parallel_out, // drives the dac
    output logic msb_out, // most significant bit
    output logic msb_out_n, // complement of msb
    output logic serial_out, // bit just loaded
    output logic conversion_done_n, // low when conversion complete
    output logic [WIDTH-1:0] result_data, // fifo head
    output logic result_valid, // fifo has a result
    input wire logic result_ready, // consumer takes result
    output logic result_overrun // result lost on full fifo
);
    logic [WIDTH-1:0] bits_r; // slave storage
    logic [WIDTH-1:0] bits_nxt;
    logic [WIDTH-1:0] ring_r; // one-hot trial marker
    logic [WIDTH-1:0] ring_nxt;
    logic done_n_r;
    logic sout_r;
    logic push_r;
    logic ovr_r;
    result_t push_word_r; // completed code, carried at the widest variant's width
    logic fifo_in_ready;
    logic [WIDTH-1:0] fifo_dout;
    logic fifo_out_valid;
    // loading edges since the last start, read only by the reset and completion checks
    localparam int CW = $clog2(WIDTH + 1);
    logic [CW-1:0] load_cnt_r;

    // the trial position is kept apart from data so a loaded zero is never
    // mistaken for the trial marker; the marker walks msb to lsb
    wire active = done_n_r && !enable_n;
    wire last_bit = ring_r[0];
    wire [WIDTH-1:0] ring_shift = ring_r >> 1;

    // next state: load the trial bit, mark the next lower one
    always_comb begin
        bits_nxt = bits_r;
        ring_nxt = ring_r;
        for (int i = 0; i < WIDTH; i++) begin
            if (ring_r[i]) begin
                bits_nxt[i] = serial_in;
            end
            if (ring_shift[i]) begin
                bits_nxt[i] = TRIAL_LEVEL;
            end
        end
        ring_nxt = ring_shift;
    end

    // storage updates only on the rising edge
    always_ff @(posedge clk) begin
        if (sys_rst || !start_n) begin
            bits_r <= {TRIAL_LEVEL, {(WIDTH-1){UNTRIED_LEVEL}}};
            ring_r <= {1'b1, {(WIDTH-1){1'b0}}};
            done_n_r <= 1'b1;
            sout_r <= 1'b0;
        end else if (active) begin
            bits_r <= bits_nxt;
            ring_r <= ring_nxt;
            sout_r <= serial_in;
            if (last_bit) begin
                done_n_r <= 1'b0;
            end
        end
    end

    // completed code goes to the fifo once per conversion; a full fifo
    // drops the word and flags it rather than stalling the converter,
    // since the analog loop cannot wait
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            push_r <= 1'b0;
            push_word_r <= '0;
            ovr_r <= 1'b0;
        end else begin
            push_r <= active && start_n && last_bit;
            push_word_r.code <= WIDTH_WIDE'(bits_nxt);
            if (!start_n) begin
                ovr_r <= 1'b0;
            end
            if (push_r && !fifo_in_ready) begin
                ovr_r <= 1'b1;
            end
        end
    end

    // loads counted since start; stops by itself once done falls
    always_ff @(posedge clk) begin
        if (sys_rst || !start_n) begin
            load_cnt_r <= '0;
        end else if (active) begin
            load_cnt_r <= load_cnt_r + 1'b1;
        end
    end

    result_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(push_word_r.code[WIDTH-1:0]),
        .in_valid(push_r),
        .in_ready(fifo_in_ready),
        .out_data(fifo_dout),
        .out_valid(fifo_out_valid),
        .out_ready(result_ready)
    );

    // outputs; the cascade enable masks the msb high
    // the mask stays combinational: a registered one would show a stale msb
    // to the dac on the first trial edge after the upper device completes
    wire msb_masked = bits_r[WIDTH-1] | enable_n;
    assign parallel_out = {msb_masked, bits_r[WIDTH-2:0]};
    assign msb_out = msb_masked;
    assign msb_out_n = ~msb_masked;
    assign serial_out = sout_r;
    assign conversion_done_n = done_n_r;
    assign result_data = fifo_dout;
    assign result_valid = fifo_out_valid;
    assign result_overrun = ovr_r;

    // continuous mode: hold start low on the edge after done falls
    sequence s_reset;
        !start_n;
    endsequence

    // start released with the enable low and a conversion still open
    sequence s_first_load;
        start_n && !enable_n && done_n_r;
    endsequence

    // an edge on which the trial bit takes the comparator decision
    sequence s_load_edge;
        active && start_n;
    endsequence

    // start resets the register whatever state it was in
    a_reset_state: assert property (@(posedge clk) disable iff (sys_rst)
        s_reset |=> (done_n_r && !bits_r[WIDTH-1] && bits_r[WIDTH-2:0] == '1))
        else $error("start did not reset register");
    a_reset_side: assert property (@(posedge clk) disable iff (sys_rst)
        s_reset |=> (!serial_out && load_cnt_r == '0))
        else $error("start left stale serial or count state");

    // completion comes after exactly WIDTH loads and then holds
    a_done_after_width: assert property (@(posedge clk) disable iff (sys_rst)
        (ring_r[0] && active && start_n) |=> !done_n_r)
        else $error("done not asserted after lsb");
    a_done_count: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(done_n_r) |-> load_cnt_r == CW'(WIDTH))
        else $error("done fell after the wrong number of loads");
    a_count_bound: assert property (@(posedge clk) disable iff (sys_rst)
        load_cnt_r <= CW'(WIDTH))
        else $error("register loaded after completion");
    a_lsb_last: assert property (@(posedge clk) disable iff (sys_rst)
        (s_load_edge ##0 last_bit) |=> (!done_n_r && ring_r == '0))
        else $error("trial marker left after lsb");
    a_frozen_when_done: assert property (@(posedge clk) disable iff (sys_rst)
        (!done_n_r && start_n) |=> $stable(bits_r))
        else $error("bits changed after completion");
    a_done_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (!done_n_r && start_n) |=> (!done_n_r && $stable(serial_out) && !push_r))
        else $error("completed register did not stay frozen");

    // one bit per edge, msb first, the next one marked low
    a_load_trial: assert property (@(posedge clk) disable iff (sys_rst)
        (active && start_n && ring_r[WIDTH-1]) |=> bits_r[WIDTH-1] == $past(serial_in))
        else $error("msb did not take serial data");
    a_next_trial_low: assert property (@(posedge clk) disable iff (sys_rst)
        (active && start_n && ring_r[WIDTH-1]) |=> !bits_r[WIDTH-2])
        else $error("next bit not set low");
    a_start_then_trial: assert property (@(posedge clk) disable iff (sys_rst)
        s_reset ##1 s_first_load |=> ring_r[WIDTH-2] && bits_r[WIDTH-2] == TRIAL_LEVEL)
        else $error("first load did not move the trial bit");
    a_trial_walk: assert property (@(posedge clk) disable iff (sys_rst)
        (s_load_edge ##0 !last_bit) |=> ring_r == $past(ring_shift))
        else $error("trial marker did not step one place");
    a_trial_onehot: assert property (@(posedge clk) disable iff (sys_rst)
        $onehot0(ring_r))
        else $error("more than one trial bit");
    a_serial_echo: assert property (@(posedge clk) disable iff (sys_rst)
        (active && start_n) |=> serial_out == $past(serial_in))
        else $error("serial output mismatch");

    // the finished code reaches the fifo once, or is flagged as lost
    a_push_word: assert property (@(posedge clk) disable iff (sys_rst)
        (s_load_edge ##0 last_bit) |=> (push_r && push_word_r.code[WIDTH-1:0] == bits_r))
        else $error("finished code not pushed");
    a_overrun_flag: assert property (@(posedge clk) disable iff (sys_rst)
        (push_r && !fifo_in_ready) |=> result_overrun)
        else $error("lost result not flagged");

    // cascade masking and the complementary msb
    a_enable_holds: assert property (@(posedge clk) disable iff (sys_rst)
        (enable_n && start_n) |-> msb_out ##1 $stable(bits_r))
        else $error("disabled register accepted data");
    a_msb_forced: assert property (@(posedge clk) disable iff (sys_rst)
        enable_n |-> (parallel_out[WIDTH-1] && !msb_out_n))
        else $error("enable did not force the msb high");
    a_msb_complement: assert property (@(posedge clk) disable iff (sys_rst)
        msb_out_n != msb_out)
        else $error("msb complement wrong");
endmodule // sar_register
`default_nettype wire

// >>> testbench/sar_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sar_partner (
    input wire logic [7:0] dac_code, // register outputs into the dac
    input wire logic [7:0] level, // analog input held as a code
    output logic decision // comparator result to serial_in
);
    // a low bit adds weight, so compare the inverted word; moves only after edges
    assign decision = ((~dac_code) > level);
endmodule // sar_partner
`default_nettype wire

// >>> testbench/successive_approximation_register_bench.sv
`timescale 1ns/1ps
`default_nettype none
module successive_approximation_register_bench import sar_pkg::*;;
    logic clk, sys_rst, start_n, enable_n, serial_in, result_ready;
    logic [7:0] level, parallel_out, result_data;
    logic msb_out, msb_out_n, serial_out, done_n, result_valid, result_overrun;
    int n_mismatch, check_count;
    sar_register #(.WIDTH(8), .DEPTH(32)) i_dut (.clk(clk), .sys_rst(sys_rst),
        .start_n(start_n), .enable_n(enable_n), .serial_in(serial_in),
        .parallel_out(parallel_out), .msb_out(msb_out), .msb_out_n(msb_out_n),
        .serial_out(serial_out), .conversion_done_n(done_n), .result_data(result_data),
        .result_valid(result_valid), .result_ready(result_ready),
        .result_overrun(result_overrun));
    sar_partner i_far (.dac_code(parallel_out), .level(level), .decision(serial_in));
    // free running clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        check_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    // one start pulse, then a walk of eight loading edges
    task automatic convert(input logic [7:0] t);
        level = t;
        @(negedge clk) start_n = 1'b0;
        @(negedge clk) start_n = 1'b1;
        check(parallel_out, 8'h7f);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk);
            check(8'(serial_out), 8'(!t[i]));
            check(8'(done_n), 8'(i != 0));
            if (i > 0) check(8'(parallel_out[i-1]), 8'(TRIAL_LEVEL));
        end
        check(parallel_out, ~t);
        check(8'(msb_out_n), 8'(t[7]));
    endtask
    // results leave the fifo oldest first; wait covers the two cycle push delay
    task automatic drain(input logic [7:0] mul, input int n);
        repeat (3) @(negedge clk);
        for (int k = 0; k < n; k++) begin
            check(8'(result_valid), 8'h01);
            check(result_data, ~(mul * 8'(k)));
            result_ready = 1'b1;
            @(negedge clk) result_ready = 1'b0;
            @(negedge clk);
        end
        check(8'(result_valid), 8'h00);
    endtask
    task automatic t_convert;
        for (int k = 0; k < 4; k++) convert(8'h55 * 8'(k));
        repeat (4) @(negedge clk);
        check(parallel_out, 8'h00);
        drain(8'h55, 4);
        $display("test convert done");
    endtask
    // a held enable keeps the msb high and takes no data
    task automatic t_cascade;
        level = 8'h00;
        enable_n = 1'b1;
        @(negedge clk) start_n = 1'b0;
        @(negedge clk) start_n = 1'b1;
        repeat (10) @(negedge clk);
        check({msb_out, parallel_out[6:0]}, 8'hff);
        check(8'(done_n), 8'h01);
        enable_n = 1'b0;
        repeat (8) @(negedge clk);
        check(8'(done_n), 8'h00);
        drain(8'h00, 1);
        $display("test cascade done");
    endtask
    task automatic t_overrun;
        for (int k = 0; k < 33; k++) convert(8'h07 * 8'(k));
        repeat (3) @(negedge clk);
        check(8'(result_overrun), 8'h01);
        drain(8'h07, 32);
        @(negedge clk) start_n = 1'b0;
        @(negedge clk) start_n = 1'b1;
        check(8'(result_overrun), 8'h00);
        $display("test overrun done");
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // a hang is cut short well after the expected run of about 500 cycles
    initial begin
        #(40 * 4000);
        n_mismatch++;
        print_verdict;
    end
    initial begin
        {sys_rst, start_n, enable_n, result_ready, level} = {4'b1100, 8'h00};
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        check(parallel_out, 8'h7f);
        check({done_n, msb_out, result_valid, result_overrun}, 8'h08);
        t_convert;
        t_cascade;
        t_overrun;
        print_verdict;
    end
endmodule // successive_approximation_register_bench
`default_nettype wire
